// ==== hw/link_sel_pkg.sv ====
// Overview of operation
// - At power-up light all indicators, then alternate USB and serial indicators.
// - Automatic selection attaches to whichever host link is receiving data.
// - An attached link blinks only its own indicator, USB or serial.
// - With no data on any link, stay scanning with alternating indicators.
// - Button press locks one link and holds its indicator steadily on.
// - A locked link's indicator blinks while data flows on that link.
// - Repeated presses step the states and return to automatic scanning.
// - One state is infrared test mode; remote keys drive the outputs.
// - Infrared test mode disables both USB and serial host links.
// - Remote keys toggle motors one to three on/off and fast/slow.
// - Receiver-select keys drive motor four; its speed is fixed.
// - Each motor output is forward, backward or off with eight speeds.
// - USB host link runs at full speed, 12 Mbit/s.
package link_sel_pkg;

  localparam int CLK_HZ           = 10_000_000;
  localparam int LAMP_TEST_MS     = 1000;
  localparam int BLINK_HALF_MS    = 250;
  localparam int ACTIVITY_HOLD_MS = 500;
  localparam int DEBOUNCE_MS      = 20;
  localparam int PWM_STEP_US      = 100;
  localparam int LAMP_TEST_CYC     = LAMP_TEST_MS * (CLK_HZ / 1000);
  localparam int BLINK_HALF_CYC    = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int ACTIVITY_HOLD_CYC = ACTIVITY_HOLD_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYC      = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int PWM_STEP_CYC      = PWM_STEP_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W             = 24;
  localparam int PRE_W             = 10;

  // USB link speed figure and the full-speed select level
  localparam int   USB_BIT_RATE   = 12_000_000;
  localparam logic USB_FULL_SPEED = 1'h1;

  localparam int             NUM_MOTORS    = 4;
  localparam int             NUM_IR_MOTORS = 3;
  localparam int             SPEED_W       = 3;
  localparam logic [2:0]     SPEED_FAST    = 3'h7;
  localparam logic [2:0]     SPEED_SLOW    = 3'h3;
  localparam logic [2:0]     SPEED_MOTOR4  = 3'h7;
  localparam int             IR_KEY_W      = 4;
  localparam logic [3:0]     KEY_ONOFF_BASE = 4'h0;
  localparam logic [3:0]     KEY_SPEED_BASE = 4'h3;
  localparam logic [3:0]     KEY_RX1        = 4'h6;
  localparam logic [3:0]     KEY_RX2        = 4'h7;

  typedef enum logic [1:0] {DIR_OFF, DIR_FWD, DIR_BWD} motor_dir_t;
  typedef struct packed {
    motor_dir_t         dir;
    logic [SPEED_W-1:0] speed;
  } motor_cmd_t;
  typedef struct packed {
    logic fwd;
    logic bwd;
  } motor_drive_t;
  typedef struct packed {
    logic usb;
    logic serial;
    logic ir;
  } led_t;
  typedef enum logic [2:0] {SEL_LAMP, SEL_AUTO, SEL_USB, SEL_SERIAL, SEL_IR} sel_mode_t;
  typedef enum logic [1:0] {ATT_NONE, ATT_USB, ATT_SERIAL} attach_t;

endpackage

// ==== hw/button_debounce.sv ====
`timescale 1ns/1ps
module button_debounce #(
  parameter int DEBOUNCE_CYC = link_sel_pkg::DEBOUNCE_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic buttonPin,
  output logic      pressPulse
);
  import link_sel_pkg::*;

  logic             sync1_r;
  logic             sync2_r;
  logic             stable_r;
  logic             stable_nxt;
  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic             press_r;
  logic             press_nxt;

  // Filter: the synced level must differ from the stable one for the full window
  always_comb begin
    stable_nxt = stable_r;
    cnt_nxt    = '0;
    press_nxt  = 1'h0;
    if (sync2_r != stable_r) begin
      if (cnt_r == TMR_W'(DEBOUNCE_CYC - 1)) begin
        stable_nxt = sync2_r;
        press_nxt  = sync2_r; // Only the pressed edge counts
      end else begin
        cnt_nxt = cnt_r + TMR_W'(1);
      end
    end
  end

  // Pin passes two flops before the filter reads it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r  <= 1'h0;
      sync2_r  <= 1'h0;
      stable_r <= 1'h0;
      cnt_r    <= '0;
      press_r  <= 1'h0;
    end else if (clkEn) begin
      sync1_r  <= buttonPin;
      sync2_r  <= sync1_r;
      stable_r <= stable_nxt;
      cnt_r    <= cnt_nxt;
      press_r  <= press_nxt;
    end
  end

  assign pressPulse = press_r && clkEn;

  AST_ONE_PULSE_PER_PRESS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pressPulse ##1 clkEn) |-> !pressPulse)
    else $error("press pulse lasted more than one enabled cycle");

endmodule

// ==== hw/motor_pwm.sv ====
`timescale 1ns/1ps
module motor_pwm (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clkEn,
  input  wire link_sel_pkg::motor_cmd_t   cmd,
  input  wire logic [2:0]                 pwmPhase,
  output link_sel_pkg::motor_drive_t      drive
);
  import link_sel_pkg::*;

  motor_drive_t drive_r;
  motor_drive_t drive_nxt;
  logic         onNow;

  // Speed n gives a duty of (n+1)/8, so eight levels plus off
  always_comb begin
    onNow         = (pwmPhase <= cmd.speed);
    drive_nxt.fwd = onNow && (cmd.dir == DIR_FWD);
    drive_nxt.bwd = onNow && (cmd.dir == DIR_BWD);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= '0;
    end else if (clkEn) begin
      drive_r <= drive_nxt;
    end
  end

  assign drive = drive_r;

  AST_MOTOR_OFF_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && cmd.dir == DIR_OFF) |=> (!drive.fwd && !drive.bwd))
    else $error("motor driven while commanded off");
  AST_MOTOR_NEVER_BOTH: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(drive.fwd && drive.bwd))
    else $error("motor driven both ways at once");

endmodule

// ==== hw/host_link_selector.sv ====
`timescale 1ns/1ps
module host_link_selector #(
  parameter int LAMP_TEST_CYC     = link_sel_pkg::LAMP_TEST_CYC,
  parameter int BLINK_HALF_CYC    = link_sel_pkg::BLINK_HALF_CYC,
  parameter int ACTIVITY_HOLD_CYC = link_sel_pkg::ACTIVITY_HOLD_CYC,
  parameter int DEBOUNCE_CYC      = link_sel_pkg::DEBOUNCE_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clkEn,
  input  wire logic                       selectButton,
  input  wire logic                       usbRxPulse,
  input  wire logic                       serialRxPulse,
  input  wire logic                       irKeyValid,
  input  wire logic [3:0]                 irKeyCode,
  input  wire link_sel_pkg::motor_cmd_t   hostMotorCmd [link_sel_pkg::NUM_MOTORS],
  output logic                            usbLinkEnable,
  output logic                            serialLinkEnable,
  output logic                            usbFullSpeed,
  output link_sel_pkg::led_t              ledState,
  output link_sel_pkg::motor_drive_t      motorDrive [link_sel_pkg::NUM_MOTORS]
);
  import link_sel_pkg::*;

  // Key decoding shared by the on/off and speed paths of motors one to three
  function automatic logic isOnOffKey(input logic [3:0] code, input int m);
    isOnOffKey = (code == KEY_ONOFF_BASE + 4'(m));
  endfunction
  function automatic logic isSpeedKey(input logic [3:0] code, input int m);
    isSpeedKey = (code == KEY_SPEED_BASE + 4'(m));
  endfunction

  logic             pressPulse;
  sel_mode_t        mode_r;
  sel_mode_t        mode_nxt;
  logic [TMR_W-1:0] lampCnt_r;
  logic [TMR_W-1:0] lampCnt_nxt;
  logic [TMR_W-1:0] blinkCnt_r;
  logic [TMR_W-1:0] blinkCnt_nxt;
  logic             blinkPhase_r;
  logic             blinkPhase_nxt;
  logic [TMR_W-1:0] usbHold_r;
  logic [TMR_W-1:0] usbHold_nxt;
  logic [TMR_W-1:0] serialHold_r;
  logic [TMR_W-1:0] serialHold_nxt;
  attach_t          attach_r;
  attach_t          attach_nxt;
  logic             usbActive;
  logic             serialActive;
  logic             usbRxSeen;
  logic             serialRxSeen;
  motor_cmd_t       irCmd_r [NUM_MOTORS];
  motor_cmd_t       irCmd_nxt [NUM_MOTORS];
  motor_cmd_t       cmdSel [NUM_MOTORS];
  logic [PRE_W-1:0] pwmPre_r;
  logic [PRE_W-1:0] pwmPre_nxt;
  logic [2:0]       pwmPhase_r;
  logic [2:0]       pwmPhase_nxt;
  led_t             led_r;
  led_t             led_nxt;
  logic             usbEn_r;
  logic             usbEn_nxt;
  logic             serialEn_r;
  logic             serialEn_nxt;

  button_debounce #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_debounce (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .buttonPin  (selectButton),
    .pressPulse (pressPulse)
  );

  // Mode sequencing: lamp test, then the button cycles through the link choices
  always_comb begin
    mode_nxt    = mode_r;
    lampCnt_nxt = lampCnt_r;
    case (mode_r)
      SEL_LAMP: begin
        if (lampCnt_r == TMR_W'(LAMP_TEST_CYC - 1)) begin
          mode_nxt = SEL_AUTO;
        end else begin
          lampCnt_nxt = lampCnt_r + TMR_W'(1);
        end
      end
      SEL_AUTO: begin
        if (pressPulse) mode_nxt = SEL_USB;
      end
      SEL_USB: begin
        if (pressPulse) mode_nxt = SEL_SERIAL;
      end
      SEL_SERIAL: begin
        if (pressPulse) mode_nxt = SEL_IR;
      end
      SEL_IR: begin
        if (pressPulse) mode_nxt = SEL_AUTO;
      end
      default: begin
        mode_nxt = SEL_AUTO;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r    <= SEL_LAMP;
      lampCnt_r <= '0;
    end else if (clkEn) begin
      mode_r    <= mode_nxt;
      lampCnt_r <= lampCnt_nxt;
    end
  end

  // Shared blink clock so alternating indicators stay in exact antiphase
  always_comb begin
    blinkCnt_nxt   = blinkCnt_r + TMR_W'(1);
    blinkPhase_nxt = blinkPhase_r;
    if (blinkCnt_r == TMR_W'(BLINK_HALF_CYC - 1)) begin
      blinkCnt_nxt   = '0;
      blinkPhase_nxt = !blinkPhase_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blinkCnt_r   <= '0;
      blinkPhase_r <= 1'h0;
    end else if (clkEn) begin
      blinkCnt_r   <= blinkCnt_nxt;
      blinkPhase_r <= blinkPhase_nxt;
    end
  end

  // Activity detection; a disabled link's receive strobes are ignored
  assign usbRxSeen    = usbRxPulse && usbEn_r;
  assign serialRxSeen = serialRxPulse && serialEn_r;
  assign usbActive    = (usbHold_r != '0);
  assign serialActive = (serialHold_r != '0);

  always_comb begin
    usbHold_nxt    = usbActive ? usbHold_r - TMR_W'(1) : '0;
    serialHold_nxt = serialActive ? serialHold_r - TMR_W'(1) : '0;
    if (usbRxSeen) usbHold_nxt = TMR_W'(ACTIVITY_HOLD_CYC);
    if (serialRxSeen) serialHold_nxt = TMR_W'(ACTIVITY_HOLD_CYC);
    attach_nxt = attach_r;
    if (mode_r != SEL_AUTO) begin
      attach_nxt = ATT_NONE;
    end else begin
      case (attach_r)
        ATT_NONE: begin
          // USB wins a tie; the other link is then ignored until this one idles
          if (usbRxSeen) attach_nxt = ATT_USB;
          else if (serialRxSeen) attach_nxt = ATT_SERIAL;
        end
        ATT_USB: begin
          if (!usbActive) attach_nxt = ATT_NONE;
        end
        ATT_SERIAL: begin
          if (!serialActive) attach_nxt = ATT_NONE;
        end
        default: begin
          attach_nxt = ATT_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      usbHold_r    <= '0;
      serialHold_r <= '0;
      attach_r     <= ATT_NONE;
    end else if (clkEn) begin
      usbHold_r    <= usbHold_nxt;
      serialHold_r <= serialHold_nxt;
      attach_r     <= attach_nxt;
    end
  end

  // Link enables and indicators, registered so the pins never glitch
  always_comb begin
    usbEn_nxt    = 1'h0;
    serialEn_nxt = 1'h0;
    led_nxt      = '0;
    case (mode_r)
      SEL_LAMP: begin
        led_nxt = '1;
      end
      SEL_AUTO: begin
        usbEn_nxt    = (attach_r != ATT_SERIAL);
        serialEn_nxt = (attach_r != ATT_USB);
        if (attach_r == ATT_NONE) begin
          led_nxt.usb    = blinkPhase_r;
          led_nxt.serial = !blinkPhase_r;
        end else begin
          led_nxt.usb    = (attach_r == ATT_USB) && blinkPhase_r;
          led_nxt.serial = (attach_r == ATT_SERIAL) && blinkPhase_r;
        end
      end
      SEL_USB: begin
        usbEn_nxt   = 1'h1;
        led_nxt.usb = usbActive ? blinkPhase_r : 1'h1;
      end
      SEL_SERIAL: begin
        serialEn_nxt   = 1'h1;
        led_nxt.serial = serialActive ? blinkPhase_r : 1'h1;
      end
      SEL_IR: begin
        led_nxt.ir = 1'h1; // Both host links stay off here
      end
      default: begin
        led_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      usbEn_r    <= 1'h0;
      serialEn_r <= 1'h0;
      led_r      <= '0;
    end else if (clkEn) begin
      usbEn_r    <= usbEn_nxt;
      serialEn_r <= serialEn_nxt;
      led_r      <= led_nxt;
    end
  end

  // Remote key handling; state is cleared on every entry to the test mode
  always_comb begin
    for (int m = 0; m < NUM_MOTORS; m++) begin
      irCmd_nxt[m] = irCmd_r[m];
    end
    if (mode_r != SEL_IR) begin
      for (int m = 0; m < NUM_IR_MOTORS; m++) begin
        irCmd_nxt[m] = '{dir: DIR_OFF, speed: SPEED_FAST};
      end
      irCmd_nxt[NUM_MOTORS-1] = '{dir: DIR_OFF, speed: SPEED_MOTOR4};
    end else if (irKeyValid) begin
      for (int m = 0; m < NUM_IR_MOTORS; m++) begin
        if (isOnOffKey(irKeyCode, m)) begin
          irCmd_nxt[m].dir = (irCmd_r[m].dir == DIR_OFF) ? DIR_FWD : DIR_OFF;
        end
        if (isSpeedKey(irKeyCode, m)) begin
          irCmd_nxt[m].speed = (irCmd_r[m].speed == SPEED_FAST) ? SPEED_SLOW : SPEED_FAST;
        end
      end
      // Receiver-select keys double as forward and backward for motor four
      if (irKeyCode == KEY_RX1) begin
        irCmd_nxt[NUM_MOTORS-1].dir = (irCmd_r[NUM_MOTORS-1].dir == DIR_FWD) ? DIR_OFF : DIR_FWD;
      end
      if (irKeyCode == KEY_RX2) begin
        irCmd_nxt[NUM_MOTORS-1].dir = (irCmd_r[NUM_MOTORS-1].dir == DIR_BWD) ? DIR_OFF : DIR_BWD;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int m = 0; m < NUM_MOTORS; m++) begin
        irCmd_r[m] <= '0;
      end
    end else if (clkEn) begin
      for (int m = 0; m < NUM_MOTORS; m++) begin
        irCmd_r[m] <= irCmd_nxt[m];
      end
    end
  end

  // Common pwm phase, one step per prescaler wrap
  always_comb begin
    pwmPre_nxt   = pwmPre_r + PRE_W'(1);
    pwmPhase_nxt = pwmPhase_r;
    if (pwmPre_r == PRE_W'(PWM_STEP_CYC - 1)) begin
      pwmPre_nxt   = '0;
      pwmPhase_nxt = pwmPhase_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmPre_r   <= '0;
      pwmPhase_r <= '0;
    end else if (clkEn) begin
      pwmPre_r   <= pwmPre_nxt;
      pwmPhase_r <= pwmPhase_nxt;
    end
  end

  // Motors follow the remote in test mode, the host otherwise, nothing in lamp test
  genvar g;
  generate
    for (g = 0; g < NUM_MOTORS; g++) begin : gMotor
      always_comb begin
        if (mode_r == SEL_IR) cmdSel[g] = irCmd_r[g];
        else if (mode_r == SEL_LAMP) cmdSel[g] = '0;
        else cmdSel[g] = hostMotorCmd[g];
      end
      motor_pwm u_pwm (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .cmd      (cmdSel[g]),
        .pwmPhase (pwmPhase_r),
        .drive    (motorDrive[g])
      );
    end
  endgenerate

  assign usbLinkEnable    = usbEn_r;
  assign serialLinkEnable = serialEn_r;
  assign usbFullSpeed     = USB_FULL_SPEED;
  assign ledState         = led_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence pressIn(sel_mode_t m);
    clkEn && pressPulse && mode_r == m;
  endsequence

  AST_LAMP_ALL_ON: assert property (
    (rst_n && clkEn && mode_r == SEL_LAMP) |=>
      (ledState == '1 && !usbLinkEnable && !serialLinkEnable))
    else $error("lamp test did not light every indicator");
  AST_AUTO_ATTACH: assert property (
    (clkEn && mode_r == SEL_AUTO && attach_r == ATT_NONE && usbRxSeen) |=> attach_r == ATT_USB)
    else $error("auto mode did not attach to the receiving link");
  AST_ACTIVE_ONE_LED: assert property (
    (clkEn && mode_r == SEL_AUTO && attach_r == ATT_USB) |=> (!ledState.serial && !ledState.ir))
    else $error("attached link shows a foreign indicator");
  AST_SCAN_ALTERNATE: assert property (
    (clkEn && mode_r == SEL_AUTO && attach_r == ATT_NONE) |=> (ledState.usb != ledState.serial))
    else $error("scan indicators not alternating");
  AST_LOCK_STEADY: assert property (
    (clkEn && mode_r == SEL_USB && !usbActive) |=> (ledState.usb && !serialLinkEnable))
    else $error("locked link indicator not steady");
  AST_LOCK_BLINK: assert property (
    (clkEn && mode_r == SEL_SERIAL && serialActive) |=> ledState.serial == $past(blinkPhase_r))
    else $error("locked link indicator not blinking with data");
  AST_PRESS_CYCLE: assert property (
    (pressIn(SEL_AUTO) |=> mode_r == SEL_USB) and (pressIn(SEL_IR) |=> mode_r == SEL_AUTO))
    else $error("button did not step the selection correctly");
  AST_IR_LINKS_OFF: assert property (
    (clkEn && mode_r == SEL_IR) |=> (!usbLinkEnable && !serialLinkEnable && ledState.ir))
    else $error("host link enabled in infrared test mode");
  AST_IR_TOGGLE: assert property (
    (clkEn && mode_r == SEL_IR && irKeyValid && irKeyCode == KEY_ONOFF_BASE) |=>
      irCmd_r[0].dir != $past(irCmd_r[0].dir))
    else $error("on/off key did not toggle motor one");
  AST_M4_SPEED_FIXED: assert property (
    (mode_r == SEL_IR) |-> irCmd_r[NUM_MOTORS-1].speed == SPEED_MOTOR4)
    else $error("motor four speed changed by the remote");
  AST_USB_FULL: assert property (
    usbLinkEnable |-> usbFullSpeed)
    else $error("usb link enabled below full speed");

endmodule

// ==== bench/host_pc_model.sv ====
`timescale 1ns/1ps
module host_pc_model #(
  parameter int GAP = 3
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic usbTalk,
  input  wire logic serialTalk,
  output logic      usbRxPulse,
  output logic      serialRxPulse
);
  logic [7:0] gapCnt_r;

  // One item every GAP cycles; link enables are not consulted, a real PC keeps talking
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt_r      <= 8'h00;
      usbRxPulse    <= 1'b0;
      serialRxPulse <= 1'b0;
    end else begin
      gapCnt_r      <= (gapCnt_r == 8'(GAP - 1)) ? 8'h00 : gapCnt_r + 8'h01;
      usbRxPulse    <= usbTalk && (gapCnt_r == 8'h00);
      serialRxPulse <= serialTalk && (gapCnt_r == 8'h00);
    end
  end
endmodule

// ==== bench/test_host_link_selector.sv ====
`timescale 1ns/1ps
module test_host_link_selector;
  import link_sel_pkg::*;
  logic         core_clk;
  logic         rst_n;
  logic         clkEn;
  logic         selectButton;
  logic         usbTalk;
  logic         serialTalk;
  logic         usbRxPulse;
  logic         serialRxPulse;
  logic         irKeyValid;
  logic [3:0]   irKeyCode;
  motor_cmd_t   hostCmd [NUM_MOTORS];
  logic         usbLinkEnable;
  logic         serialLinkEnable;
  logic         usbFullSpeed;
  led_t         ledState;
  motor_drive_t motorDrive [NUM_MOTORS];
  int           errorCnt;
  int           compares;

  // Short counts keep the run small; expectations below assume these figures
  host_link_selector #(.LAMP_TEST_CYC(20), .BLINK_HALF_CYC(4), .ACTIVITY_HOLD_CYC(30),
    .DEBOUNCE_CYC(3)) dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .selectButton(selectButton), .usbRxPulse(usbRxPulse), .serialRxPulse(serialRxPulse),
    .irKeyValid(irKeyValid), .irKeyCode(irKeyCode), .hostMotorCmd(hostCmd),
    .usbLinkEnable(usbLinkEnable), .serialLinkEnable(serialLinkEnable),
    .usbFullSpeed(usbFullSpeed), .ledState(ledState), .motorDrive(motorDrive));

  host_pc_model #(.GAP(3)) host (.core_clk(core_clk), .rst_n(rst_n), .usbTalk(usbTalk),
    .serialTalk(serialTalk), .usbRxPulse(usbRxPulse), .serialRxPulse(serialRxPulse));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Settled sampling point: one step after the rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  // Bounded wait for masked indicator value; running out ends the run
  task automatic waitLed(input logic [2:0] mask, input logic [2:0] val, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      tick(1);
      if ((ledState & mask) === val) break;
    end
    chk(8'(ledState & mask), 8'(val));
    if (i == lim) summarize();
  endtask

  task automatic waitDrv(input int idx, input logic [1:0] val, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      tick(1);
      if (motorDrive[idx] === val) break;
    end
    chk(8'(motorDrive[idx]), 8'(val));
    if (i == lim) summarize();
  endtask

  task automatic press();
    @(posedge core_clk);
    selectButton <= 1'b1;
    repeat (12) @(posedge core_clk);
    selectButton <= 1'b0;
    tick(12);
  endtask

  task automatic key(input logic [3:0] code);
    @(posedge core_clk);
    irKeyValid <= 1'b1;
    irKeyCode  <= code;
    @(posedge core_clk);
    irKeyValid <= 1'b0;
  endtask

  // Scan mode: indicators opposite, both seen toggling, both links open
  task automatic tScan();
    logic [1:0] seen;
    seen = 2'h0;
    repeat (12) begin
      tick(1);
      chk(8'(ledState.usb ^ ledState.serial), 8'h01);
      chk(8'({ledState.ir, usbLinkEnable, serialLinkEnable}), 8'h03);
      seen[ledState.usb] = 1'b1;
    end
    chk(8'(seen), 8'h03);
  endtask

  task automatic tLamp();
    tick(2);
    chk(8'(ledState), 8'h07);
    chk(8'({usbLinkEnable, serialLinkEnable}), 8'h00);
    chk(8'(usbFullSpeed), 8'(USB_FULL_SPEED));
    waitLed(3'h1, 3'h0, 40);
    tScan();
  endtask

  // Traffic on one link attaches it and closes the other until the hold runs out
  task automatic tAttach(input logic ser);
    logic [1:0] seen;
    seen = 2'h0;
    usbTalk    <= !ser;
    serialTalk <= ser;
    // Model gap of three plus attach and indicator stages; a scan phase could fake it
    tick(5);
    chk(8'(ledState & (ser ? 3'h4 : 3'h2)), 8'h00);
    chk(8'({usbLinkEnable, serialLinkEnable}), ser ? 8'h01 : 8'h02);
    repeat (12) begin
      tick(1);
      seen[ser ? ledState.serial : ledState.usb] = 1'b1;
    end
    chk(8'(seen), 8'h03);
    usbTalk    <= 1'b0;
    serialTalk <= 1'b0;
    tick(40);
    tScan();
  endtask

  // On the USB pass a one-cycle bounce first, then a real press into a locked link
  task automatic tLock(input logic [2:0] led, input logic ser);
    if (!ser) begin
      @(posedge core_clk);
      selectButton <= 1'b1;
      @(posedge core_clk);
      selectButton <= 1'b0;
      tick(12);
      chk(8'({usbLinkEnable, serialLinkEnable}), 8'h03);
    end
    press();
    waitLed(3'h7, led, 20);
    repeat (10) begin
      tick(1);
      chk(8'(ledState), 8'(led));
    end
    chk(8'({usbLinkEnable, serialLinkEnable}), ser ? 8'h01 : 8'h02);
    usbTalk    <= !ser;
    serialTalk <= ser;
    waitLed(3'h7, 3'h0, 12);
    usbTalk    <= ser;
    serialTalk <= !ser;
    // A blink high phase looks steady, so wait out the hold before judging
    tick(40);
    chk(8'(ledState), 8'(led));
    tick(8);
    chk(8'(ledState), 8'(led));
    usbTalk    <= 1'b0;
    serialTalk <= 1'b0;
  endtask

  task automatic tIr();
    press();
    waitLed(3'h7, 3'h1, 20);
    usbTalk    <= 1'b1;
    serialTalk <= 1'b1;
    tick(10);
    chk(8'({ledState, usbLinkEnable, serialLinkEnable}), 8'h04);
    usbTalk    <= 1'b0;
    serialTalk <= 1'b0;
    for (int m = 0; m < NUM_IR_MOTORS; m++) begin
      key(KEY_ONOFF_BASE + 4'(m));
      waitDrv(m, 2'b10, 4);
    end
    key(KEY_SPEED_BASE);
    waitDrv(0, 2'b00, 8100);
    // Back to fast first, so the off key is judged against a running motor
    key(KEY_SPEED_BASE);
    waitDrv(0, 2'b10, 4);
    key(KEY_ONOFF_BASE);
    waitDrv(0, 2'b00, 4);
    key(KEY_RX1);
    waitDrv(3, 2'b10, 4);
    key(KEY_RX1);
    key(KEY_RX2);
    waitDrv(3, 2'b01, 4);
    press();
    waitLed(3'h1, 3'h0, 20);
    tScan();
  endtask

  // Host commands drive a motor each way; lowest speed still runs one phase in eight
  task automatic tHost();
    @(posedge core_clk);
    hostCmd[2] <= '{dir: DIR_FWD, speed: 3'h7};
    waitDrv(2, 2'b10, 4);
    @(posedge core_clk);
    hostCmd[2] <= '{dir: DIR_BWD, speed: 3'h7};
    waitDrv(2, 2'b01, 4);
    @(posedge core_clk);
    hostCmd[2] <= '{dir: DIR_BWD, speed: 3'h0};
    waitDrv(2, 2'b00, 8100);
    waitDrv(2, 2'b01, 8100);
    @(posedge core_clk);
    hostCmd[2] <= '{dir: DIR_OFF, speed: 3'h7};
    waitDrv(2, 2'b00, 4);
  endtask

  initial begin
    errorCnt     = 0;
    compares     = 0;
    rst_n        = 1'b0;
    clkEn        = 1'b1;
    selectButton = 1'b0;
    usbTalk      = 1'b0;
    serialTalk   = 1'b0;
    irKeyValid   = 1'b0;
    irKeyCode    = 4'h0;
    for (int m = 0; m < NUM_MOTORS; m++) hostCmd[m] = '{dir: DIR_OFF, speed: 3'h0};
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    tLamp();
    tAttach(1'b0);
    tAttach(1'b1);
    tLock(3'h4, 1'b0);
    tLock(3'h2, 1'b1);
    tIr();
    tHost();
    summarize();
  end
endmodule
